// ---- pmoc_mac_model.sv ----
// MAC side model: sends a burst of transmit nibbles on request.
// Optionally flags the last nibble of the burst as an error.
// Assumes the block samples tx_en on the rising edge of clk.
`timescale 1ns/1ps

module pmoc_mac_model
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic       er,
	input  wire logic [3:0] len,
	output logic            tx_en,
	output logic            tx_er
);
	logic [3:0] cnt = 4'h0;

	always_ff @(posedge clk)
		cnt <= go ? len : (cnt != 4'h0 ? cnt - 4'h1 : cnt);

	assign tx_en = cnt != 4'h0;
	assign tx_er = er && cnt == 4'h1;
endmodule

// ---- pmoc_option_ctrl.sv ----
// Second option control register and the datapath options it steers.
// Assumes all inputs, including the transmit nibble stream, share clk.
//
// Operation
// - Fast bit shortens parallel detect link time
// - Either crossover mode forces fast bit set
// - Extended bit: forced-100 partner yields full duplex when AN enabled or forced 100
// - Extended bit clear: standard duplex decision used
// - LED qualify: link LED only on 100 full
// - Isolate MAC outputs on 100 half link
// - Idle symbol errors reported only when enabled
// - Odd-nibble end extends TX_EN, flags TX_ER
// - Odd-nibble disable suppresses that extension
// - Receive data reference: RX_CLK or crystal clock
`timescale 1ns/1ps

module pmoc_option_ctrl
	import pmoc_pkg::*;
#(
	parameter int PD_NORMAL_CYCLES = PMOC_PD_NORMAL_CYCLES,
	parameter int PD_FAST_CYCLES   = PMOC_PD_FAST_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        xover_fast_en,
	input  wire logic        xover_robust_en,
	input  wire logic        pd_start,
	output logic             pd_busy,
	output logic             pd_done,
	input  wire logic        an_enabled,
	input  wire logic        forced_100,
	input  wire logic        partner_forced_100,
	input  wire logic        ieee_full_duplex,
	input  wire logic        link_up,
	input  wire logic        link_100,
	output logic             link_full_duplex,
	output logic             led_link,
	output logic             mac_port_isolate,
	input  wire logic        rx_idle,
	input  wire logic        rx_symbol_err,
	output logic             rx_er_idle,
	input  wire logic        tx_en,
	input  wire logic        tx_er,
	output logic             tx_en_int,
	output logic             tx_er_int,
	output logic             rmii_rx_ref_rx_clk
);

	////////////////////////////////////////////////////////////////////////
	// Register
	logic [6:0]  phy_option_control_two;
	logic [6:0]  next_ctrl;
	logic [15:0] next_rdata;

	function automatic logic hit(input logic [4:0] a);
		return a == PMOC_ADDR_CTRL_TWO;
	endfunction

	always_comb
	begin
		next_ctrl = phy_option_control_two;
		if (reg_wr && hit(reg_addr))
			next_ctrl = reg_wdata[6:0];
		if (xover_fast_en || xover_robust_en)
			next_ctrl[PMOC_BIT_FAST_PD] = 1'b1;
		next_rdata = reg_rdata;
		if (reg_rd)
		begin
			if (hit(reg_addr))
				next_rdata = {9'h000, phy_option_control_two};
			else
				next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phy_option_control_two <= PMOC_RESET_VALUE[6:0];
			reg_rdata              <= 16'h0000;
		end
		else
		begin
			phy_option_control_two <= next_ctrl;
			reg_rdata              <= next_rdata;
		end
	end

	wire fast_pd  = phy_option_control_two[PMOC_BIT_FAST_PD];
	wire ext_fd   = phy_option_control_two[PMOC_BIT_EXT_FD];
	wire led_qual = phy_option_control_two[PMOC_BIT_LED_QUAL];
	wire iso_hd   = phy_option_control_two[PMOC_BIT_ISO_HD];
	wire idle_err = phy_option_control_two[PMOC_BIT_IDLE_ERR];
	wire odd_dis  = phy_option_control_two[PMOC_BIT_ODD_DIS];

	////////////////////////////////////////////////////////////////////////
	// Parallel detect link timer
	logic [15:0] pd_cnt;
	logic [15:0] next_pd_cnt;
	logic        next_pd_busy;
	logic        next_pd_done;

	always_comb
	begin
		next_pd_cnt  = pd_cnt;
		next_pd_busy = pd_busy;
		next_pd_done = 1'b0;
		if (pd_busy)
		begin
			if (pd_cnt == 16'h0001)
			begin
				next_pd_busy = 1'b0;
				next_pd_done = 1'b1;
			end
			next_pd_cnt = pd_cnt - 16'h0001;
		end
		else if (pd_start)
		begin
			next_pd_busy = 1'b1;
			next_pd_cnt  = fast_pd ? 16'(PD_FAST_CYCLES)
				: 16'(PD_NORMAL_CYCLES);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pd_cnt  <= 16'h0000;
			pd_busy <= 1'b0;
			pd_done <= 1'b0;
		end
		else
		begin
			pd_cnt  <= next_pd_cnt;
			pd_busy <= next_pd_busy;
			pd_done <= next_pd_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Duplex, LED, isolation, idle errors, receive reference
	logic next_fd;
	logic next_led;
	logic next_iso;
	logic next_rx_er;

	always_comb
	begin
		if (ext_fd && (an_enabled || forced_100) && partner_forced_100)
			next_fd = 1'b1;
		else
			next_fd = ieee_full_duplex;
		next_led   = link_up && (!led_qual || (link_100 && next_fd));
		next_iso   = iso_hd && link_up && link_100 && !next_fd;
		next_rx_er = idle_err && rx_idle && rx_symbol_err;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link_full_duplex   <= 1'b0;
			led_link           <= 1'b0;
			mac_port_isolate   <= 1'b0;
			rx_er_idle         <= 1'b0;
			rmii_rx_ref_rx_clk <= 1'b0;
		end
		else
		begin
			link_full_duplex   <= next_fd;
			led_link           <= next_led;
			mac_port_isolate   <= next_iso;
			rx_er_idle         <= next_rx_er;
			rmii_rx_ref_rx_clk <= phy_option_control_two[PMOC_BIT_RMII_RXCK];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit enable odd-nibble handling
	pmoc_tx_t tx_state;
	pmoc_tx_t next_tx_state;
	logic     odd;
	logic     next_odd;
	logic     next_tx_en_int;
	logic     next_tx_er_int;

	always_comb
	begin
		next_tx_state  = tx_state;
		next_odd       = odd;
		next_tx_en_int = tx_en;
		next_tx_er_int = tx_er;
		case (tx_state)
			PMOC_TX_IDLE:
			begin
				next_odd = 1'b0;
				if (tx_en)
				begin
					next_tx_state = PMOC_TX_RUN;
					next_odd      = 1'b1;
				end
			end
			PMOC_TX_RUN:
			begin
				next_odd = ~odd;
				if (!tx_en)
				begin
					if (odd && !odd_dis)
					begin
						next_tx_state  = PMOC_TX_EXT;
						next_tx_en_int = 1'b1;
						next_tx_er_int = 1'b1;
					end
					else
						next_tx_state = PMOC_TX_IDLE;
				end
			end
			default:
			begin
				next_tx_state = tx_en ? PMOC_TX_RUN : PMOC_TX_IDLE;
				next_odd      = tx_en;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_state  <= PMOC_TX_IDLE;
			odd       <= 1'b0;
			tx_en_int <= 1'b0;
			tx_er_int <= 1'b0;
		end
		else
		begin
			tx_state  <= next_tx_state;
			odd       <= next_odd;
			tx_en_int <= next_tx_en_int;
			tx_er_int <= next_tx_er_int;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_fast_timer_len: assert property (
		pd_start && !pd_busy && fast_pd |=> pd_cnt == 16'(PD_FAST_CYCLES))
		else $error("fast parallel detect length wrong");
	a_xover_sets_fast: assert property (
		xover_fast_en || xover_robust_en |=> fast_pd)
		else $error("crossover did not set fast bit");
	a_ext_full_dup: assert property (
		ext_fd && forced_100 && partner_forced_100 |=> link_full_duplex)
		else $error("extended full duplex not applied");
	a_ieee_duplex: assert property (
		!ext_fd |=> link_full_duplex == $past(ieee_full_duplex))
		else $error("duplex not following standard decision");
	a_led_qualify: assert property (
		led_qual && !(link_100 && next_fd) |=> !led_link)
		else $error("led lit outside 100 full");
	a_isolate_hd: assert property (
		iso_hd && link_up && link_100 && !next_fd |=> mac_port_isolate)
		else $error("mac port not isolated");
	a_idle_err_off: assert property (
		!idle_err |=> !rx_er_idle)
		else $error("idle error reported while disabled");
	a_odd_extend: assert property (
		tx_state == PMOC_TX_RUN && odd && !tx_en && !odd_dis
		|=> tx_en_int && tx_er_int ##1 tx_en_int == $past(tx_en))
		else $error("odd nibble end not extended");
	a_odd_disabled: assert property (
		odd_dis && !tx_en |=> !tx_en_int)
		else $error("extension while disabled");
	a_rx_ref: assert property (
		##1 rmii_rx_ref_rx_clk == $past(phy_option_control_two[0]))
		else $error("receive reference not following bit");
	a_write_read: assert property (
		reg_wr && hit(reg_addr) && !xover_fast_en && !xover_robust_en
		##1 reg_rd && hit(reg_addr) && !reg_wr
		|=> reg_rdata == {9'h000, $past(reg_wdata[6:0], 2)})
		else $error("register readback mismatch");

	c_fast_pd: cover property (pd_start && fast_pd ##[1:8] pd_done);
	c_odd_ext: cover property (tx_state == PMOC_TX_EXT);
	c_iso: cover property (mac_port_isolate);
	c_ext_fd: cover property (ext_fd && partner_forced_100 && link_full_duplex);

endmodule

// ---- pmoc_option_ctrl_tb.sv ----
// Self-checking bench for the second option control register.
// Assumes the MAC model drives the transmit nibble stream.
`timescale 1ns/1ps

module pmoc_option_ctrl_tb import pmoc_pkg::*;;
	logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
	logic        xover_fast_en = 1'b0, xover_robust_en = 1'b0;
	logic        pd_start = 1'b0, pd_busy, pd_done, go = 1'b0, er = 1'b0;
	logic [3:0]  len = 4'h0;
	logic        an_enabled = 1'b0, forced_100 = 1'b0;
	logic        partner_forced_100 = 1'b0, ieee_full_duplex = 1'b0;
	logic        link_up = 1'b0, link_100 = 1'b0, rx_idle = 1'b0;
	logic        rx_symbol_err = 1'b0, link_full_duplex, led_link;
	logic        mac_port_isolate, rx_er_idle, tx_en, tx_er;
	logic        tx_en_int, tx_er_int, rmii_rx_ref_rx_clk;
	int          fails = 0, comparisons = 0;

	pmoc_option_ctrl uut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.xover_fast_en(xover_fast_en), .xover_robust_en(xover_robust_en),
		.pd_start(pd_start), .pd_busy(pd_busy), .pd_done(pd_done),
		.an_enabled(an_enabled), .forced_100(forced_100),
		.partner_forced_100(partner_forced_100),
		.ieee_full_duplex(ieee_full_duplex), .link_up(link_up),
		.link_100(link_100), .link_full_duplex(link_full_duplex),
		.led_link(led_link), .mac_port_isolate(mac_port_isolate),
		.rx_idle(rx_idle), .rx_symbol_err(rx_symbol_err),
		.rx_er_idle(rx_er_idle), .tx_en(tx_en), .tx_er(tx_er),
		.tx_en_int(tx_en_int), .tx_er_int(tx_er_int),
		.rmii_rx_ref_rx_clk(rmii_rx_ref_rx_clk));
	pmoc_mac_model mac (.clk(clk), .go(go), .er(er), .len(len),
		.tx_en(tx_en), .tx_er(tx_er));

	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Write followed at once by a read of the same register
	task automatic wr_rd(input logic [15:0] d);
		@(posedge clk);
		reg_addr <= PMOC_ADDR_CTRL_TWO;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, {9'h000, d[6:0]});
	endtask

	task automatic pd(input int n);
		int c;
		@(posedge clk);
		pd_start <= 1'b1;
		@(posedge clk);
		pd_start <= 1'b0;
		#1 chk(16'(pd_busy), 16'h0001);
		c = 0;
		do
		begin
			@(posedge clk);
			#1 c++;
		end
		while (pd_done !== 1'b1 && c < 40);
		chk(16'(c), 16'(n));
		chk(16'(pd_busy), 16'h0000);
	endtask

	// Inputs: an, forced, partner, ieee, link, 100, idle, symbol error
	task automatic stat(input logic [15:0] d, input logic [7:0] i,
		input logic [4:0] e);
		@(posedge clk);
		{an_enabled, forced_100, partner_forced_100, ieee_full_duplex,
			link_up, link_100, rx_idle, rx_symbol_err} <= i;
		wr(PMOC_ADDR_CTRL_TWO, d);
		repeat (3) @(posedge clk);
		#1 chk({11'h000, link_full_duplex, led_link, mac_port_isolate,
			rx_er_idle, rmii_rx_ref_rx_clk}, {11'h000, e});
	endtask

	task automatic tx(input logic [15:0] d, input logic [3:0] n,
		input logic [1:0] e);
		wr(PMOC_ADDR_CTRL_TWO, d);
		@(posedge clk);
		go <= 1'b1;
		len <= n;
		@(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({14'h0000, tx_en_int, tx_er_int}, {14'h0000, e});
		@(posedge clk);
		#1 chk({14'h0000, tx_en_int, tx_er_int}, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(PMOC_ADDR_CTRL_TWO);
		chk(v, PMOC_RESET_VALUE);
		wr(PMOC_ADDR_CTRL_TWO, 16'hFFFF);
		rd(PMOC_ADDR_CTRL_TWO);
		chk(v, 16'h007F);
		wr(5'h0B, 16'h0000);
		rd(PMOC_ADDR_CTRL_TWO);
		chk(v, 16'h007F);
		rd(5'h0B);
		chk(v, 16'h0000);
		wr(PMOC_ADDR_CTRL_TWO, 16'h0000);
		rd(PMOC_ADDR_CTRL_TWO);
		chk(v, 16'h0000);
		wr_rd(16'h0041);
		$display("test registers done");
		for (int i = 1; i < 3; i++)
		begin
			@(posedge clk);
			{xover_robust_en, xover_fast_en} <= 2'(i);
			wr(PMOC_ADDR_CTRL_TWO, 16'h0000);
			rd(PMOC_ADDR_CTRL_TWO);
			chk(v, 16'h0040);
			pd(PMOC_PD_FAST_CYCLES);
		end
		@(posedge clk);
		{xover_robust_en, xover_fast_en} <= 2'b00;
		wr(PMOC_ADDR_CTRL_TWO, 16'h0000);
		pd(PMOC_PD_NORMAL_CYCLES);
		$display("test timer done");
		stat(16'h003C, 8'hAF, 5'h1A);
		stat(16'h0019, 8'hAF, 5'h05);
		stat(16'h0020, 8'h6E, 5'h18);
		stat(16'h0000, 8'h1C, 5'h18);
		stat(16'h0024, 8'h2B, 5'h0A);
		$display("test status done");
		tx(16'h0000, 4'h3, 2'b11);
		tx(16'h0002, 4'h3, 2'b00);
		tx(16'h0000, 4'h4, 2'b10);
		@(posedge clk);
		er <= 1'b1;
		tx(16'h0000, 4'h4, 2'b11);
		$display("test transmit done");
		wr(PMOC_ADDR_CTRL_TWO, 16'h007B);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(PMOC_ADDR_CTRL_TWO);
		chk(v, PMOC_RESET_VALUE);
		$display("test reset done");
		end_sim();
	end

	initial
	begin
		#(25 * 5000);
		fails++;
		end_sim();
	end
endmodule

// ---- pmoc_pkg.sv ----
// Package for the second option control register of the PHY.
// Assumes a 16-bit management register port with 5-bit register addresses.
package pmoc_pkg;

	localparam logic [4:0]  PMOC_ADDR_CTRL_TWO = 5'h0A;
	localparam logic [15:0] PMOC_RESET_VALUE   = 16'h0004;
	localparam logic [15:0] PMOC_WRITE_MASK    = 16'h007F;

	localparam int PMOC_BIT_FAST_PD   = 6;
	localparam int PMOC_BIT_EXT_FD    = 5;
	localparam int PMOC_BIT_LED_QUAL  = 4;
	localparam int PMOC_BIT_ISO_HD    = 3;
	localparam int PMOC_BIT_IDLE_ERR  = 2;
	localparam int PMOC_BIT_ODD_DIS   = 1;
	localparam int PMOC_BIT_RMII_RXCK = 0;

	localparam int PMOC_PD_NORMAL_CYCLES = 16;
	localparam int PMOC_PD_FAST_CYCLES   = 4;

	typedef enum logic [1:0] {PMOC_TX_IDLE, PMOC_TX_RUN, PMOC_TX_EXT} pmoc_tx_t;

endpackage
